// ---- hdl/synth_control_field_decode.sv ----
// Serial register capture and control-field decode of the frequency synthesizer.
`timescale 1ns/1ps

// What this block does and what it expects of the host
// RULE1 - Lockout set: only lockout bit writes accepted.
// RULE2 - Mute both outputs when unlocked and enabled.
// RULE3 - Host programs reference range code correctly.
// RULE4 - Ignore bit set: buffer pin has no effect.
// RULE5 - Method 0: start last core, else lowest.
// RULE6 - Method 1: start chosen core, skip invalid.
// RULE7 - Method 2: force chosen core; 3 reserved.
// RULE8 - Host avoids method 0 for large downward retunes.
// RULE9 - Output B source: VCO, divided, external.
// RULE10 - Output A source uses same encoding.
// RULE11 - Delay bit puts divider in feedback.
// RULE12 - Mode code 1 turns off the VCO; input pin power stays off.
// RULE13 - Power codes 0,1,3 ignore chip enable.
// RULE14 - Codes 4,6,7 depend on chip enable.
// RULE15 - Register five reset bit restores defaults.
// RULE16 - Register reset releases itself.
// RULE17 - Pulse code maps 370 to 2600 ps.
// RULE18 - Host keeps pulse code zero above 130 MHz.
// RULE19 - Lock flag uses phase measurement only.
// RULE20 - Register zero write starts calibration unless skipped.
// RULE21 - Fields change only on a latched word.
module synth_control_field_decode
   import synth_ctl_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic clk_en,
   input wire ser_pins_t ser_pins,
   input wire logic chip_enable_pin,
   input wire logic buffer_enable_pin,
   input wire logic phase_lock_raw,
   input wire logic [3:0] core_valid,
   output logic digital_lock_flag,
   output power_ctl_t power,
   output power_status_t power_status,
   output rf_route_t route,
   output logic [4:0] channel_divide_value,
   output logic [2:0] ref_freq_range,
   output logic [2:0] pump_min_pulse_code,
   output logic [11:0] pump_min_pulse_ps,
   output cal_req_t cal,
   output logic soft_reset_active,
   output logic program_lockout
);

   // ==========================================================================
   // State record: synchronisers, shift register, held words and registered outputs.
   typedef struct packed {
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_d;
      logic data_s1;
      logic data_s2;
      logic le_s1;
      logic le_s2;
      logic le_d;
      logic ce_s1;
      logic ce_s2;
      logic buf_s1;
      logic buf_s2;
      logic lock_s1;
      logic lock_s2;
      logic [31:0] shift;
      logic [31:0] r0;
      logic [31:0] r1;
      logic [31:0] r3;
      logic [31:0] r4;
      logic [31:0] r5;
      logic [31:0] r6;
      logic soft_active;
      logic [7:0] soft_cnt;
      logic [1:0] last_core;
      logic core_used;
      logic lock_flag;
      power_ctl_t power;
      power_status_t pstat;
      rf_route_t route;
      logic [4:0] chan_div;
      logic [2:0] ref_range;
      logic [2:0] pump_code;
      logic [11:0] pump_ps;
      cal_req_t cal;
   } state_t;

   state_t s_reg; // Registered state.
   state_t s_next; // Next value of the whole state.

   // ==========================================================================
   // Decode helpers.

   // Minimum charge pump on time for a pulse code, rising with the code.
   function automatic logic [11:0] pulse_ps(input logic [2:0] code);
      logic [11:0] ps;
      ps = PULSE_PS_0;
      unique case (code)
         3'h0: ps = PULSE_PS_0;
         3'h1: ps = PULSE_PS_1;
         3'h2: ps = PULSE_PS_2;
         3'h3: ps = PULSE_PS_3;
         3'h4: ps = PULSE_PS_4;
         3'h5: ps = PULSE_PS_5;
         3'h6: ps = PULSE_PS_6;
         3'h7: ps = PULSE_PS_7;
      endcase
      return ps;
   endfunction : pulse_ps

   // Device power state from the power-down code and the chip-enable pin.
   // Reserved codes keep the device powered up, the least surprising choice.
   function automatic power_status_t power_decode(input logic [2:0] code, input logic ce);
      power_status_t p;
      p = PWR_UP;
      unique case (code)
         3'h0: p = PWR_UP; // RULE13
         3'h1: p = PWR_FULL_DOWN; // RULE13
         3'h3: p = PWR_PARTIAL_DOWN; // RULE13
         3'h4: p = ce ? PWR_UP : PWR_FULL_DOWN; // RULE14
         3'h6: p = ce ? PWR_UP : PWR_PARTIAL_DOWN; // RULE14
         3'h7: p = ce ? PWR_PARTIAL_DOWN : PWR_FULL_DOWN; // RULE14
         default: p = PWR_UP;
      endcase
      return p;
   endfunction : power_decode

   // Lowest valid core other than the given one; keeps the given one if none is valid.
   function automatic logic [1:0] other_core(input logic [1:0] start, input logic [3:0] valid);
      logic [1:0] c;
      c = start;
      for (int i = 3; i >= 0; i--) begin
         if (valid[i] && (2'(i) != start)) begin
            c = 2'(i);
         end
      end
      return c;
   endfunction : other_core

   // ==========================================================================
   // Next-state logic.
   always_comb begin
      logic sclk_rise;
      logic le_rise;
      logic [31:0] word;
      logic [1:0] method;
      logic [1:0] start_core;
      logic rf_on;
      sclk_rise = 1'b0;
      le_rise = 1'b0;
      word = 32'h0000_0000;
      method = 2'h0;
      start_core = 2'h0;
      rf_on = 1'b0;
      s_next = s_reg;

      // Every pin input passes two flip-flops before anything reads it.
      s_next.sclk_s1 = ser_pins.clk;
      s_next.sclk_s2 = s_reg.sclk_s1;
      s_next.sclk_d = s_reg.sclk_s2;
      s_next.data_s1 = ser_pins.data;
      s_next.data_s2 = s_reg.data_s1;
      s_next.le_s1 = ser_pins.latch;
      s_next.le_s2 = s_reg.le_s1;
      s_next.le_d = s_reg.le_s2;
      s_next.ce_s1 = chip_enable_pin;
      s_next.ce_s2 = s_reg.ce_s1;
      s_next.buf_s1 = buffer_enable_pin;
      s_next.buf_s2 = s_reg.buf_s1;
      s_next.lock_s1 = phase_lock_raw;
      s_next.lock_s2 = s_reg.lock_s1;
      sclk_rise = s_reg.sclk_s2 & ~s_reg.sclk_d;
      le_rise = s_reg.le_s2 & ~s_reg.le_d;
      s_next.cal.start = 1'b0;

      if (s_reg.soft_active) begin
         // The register reset holds for a fixed time, then lets go by itself.
         s_next.soft_cnt = s_reg.soft_cnt - 8'h01; // RULE16
         if (s_reg.soft_cnt == 8'h01) begin
            s_next.soft_active = 1'b0; // RULE16
         end
      end else begin
         // Data is taken on each rising serial clock edge, most significant bit first.
         if (sclk_rise) begin
            s_next.shift = {s_reg.shift[30:0], s_reg.data_s2};
         end
         // Only a whole latched word touches the held registers.
         if (le_rise) begin
            word = s_reg.shift; // RULE21
            if (s_reg.r6[LOCKOUT_BIT]) begin
               // Locked out: only the lockout bit itself may still change.
               if (word[3:0] == ADDR_R6) begin
                  s_next.r6[LOCKOUT_BIT] = word[LOCKOUT_BIT]; // RULE1
               end
            end else begin
               unique case (word[3:0])
                  ADDR_R0: begin
                     s_next.r0 = word;
                     if (!word[SKIP_FREQ_CAL_BIT]) begin
                        method = s_reg.r5[CORE_PICK_LSB +: 2];
                        start_core = s_reg.r1[CORE_START_LSB +: 2];
                        s_next.cal.start = 1'b1; // RULE20
                        s_next.cal.forced = 1'b0;
                        if (method == 2'h1) begin
                           s_next.cal.core = core_valid[start_core] ? start_core
                                             : other_core(start_core, core_valid); // RULE6
                        end else if (method == 2'h2) begin
                           s_next.cal.core = start_core; // RULE7
                           s_next.cal.forced = 1'b1; // RULE7
                        end else begin
                           // Reserved method 3 falls back to method 0.
                           s_next.cal.core = s_reg.core_used ? s_reg.last_core : 2'h0; // RULE5
                        end
                        s_next.last_core = s_next.cal.core;
                        s_next.core_used = 1'b1;
                     end
                  end
                  ADDR_R1: s_next.r1 = word;
                  ADDR_R3: s_next.r3 = word;
                  ADDR_PUMP_PULSE_TIMING_CONFIG: s_next.r4 = word;
                  ADDR_R6: s_next.r6 = word; // RULE1
                  ADDR_OUTPUT_POWER_MODE_CONFIG: begin
                     if (word[SOFT_RESET_BIT]) begin
                        // Back to power-on values, including the core history.
                        s_next.r0 = R0_RESET; // RULE15
                        s_next.r1 = R1_RESET;
                        s_next.r3 = R3_RESET;
                        s_next.r4 = R4_RESET;
                        s_next.r5 = R5_RESET;
                        s_next.r6 = R6_RESET;
                        s_next.shift = 32'h0000_0000;
                        s_next.core_used = 1'b0;
                        s_next.last_core = 2'h0;
                        s_next.soft_active = 1'b1; // RULE15
                        s_next.soft_cnt = 8'(SOFT_RESET_CYCLES);
                     end else begin
                        s_next.r5 = word; // RULE15
                     end
                  end
                  default: begin
                     // Words for registers this block does not hold are dropped.
                  end
               endcase
            end
         end
      end

      // Lock flag comes only from the phase measurement, never the tuning voltage.
      s_next.lock_flag = s_reg.lock_s2; // RULE19

      // Power decode from the held words and the chip-enable pin.
      s_next.pstat = power_decode(s_reg.r5[PWDN_LSB +: 3], s_reg.ce_s2);
      s_next.power.regulators_on = (s_next.pstat != PWR_FULL_DOWN);
      s_next.power.pll_on = (s_next.pstat == PWR_UP); // RULE12
      s_next.power.vco_on = (s_next.pstat == PWR_UP) &&
                            (s_reg.r5[MODE_LSB +: 2] != 2'h1); // RULE12
      s_next.power.ext_in_on = 1'b0; // RULE12

      // The outputs need the buffer pin unless it is ignored, and lock when muting is on.
      rf_on = (s_reg.r5[BUF_IGNORE_BIT] || s_reg.buf_s2) && // RULE4
              !(s_reg.r5[MUTE_BIT] && !s_reg.lock_s2) && // RULE2
              (s_next.pstat == PWR_UP);
      s_next.route.out_a_sel = s_reg.r5[OUT_A_SRC_LSB +: 2]; // RULE10
      s_next.route.out_b_sel = s_reg.r5[OUT_B_SRC_LSB +: 2]; // RULE9
      // A reserved source code leaves that output off rather than guessing a source.
      s_next.route.out_a_en = rf_on && (s_reg.r5[OUT_A_SRC_LSB +: 2] != 2'h3); // RULE10
      s_next.route.out_b_en = rf_on && (s_reg.r5[OUT_B_SRC_LSB +: 2] != 2'h3); // RULE9
      s_next.route.feedback_from_divider = s_reg.r5[DET_DELAY_BIT]; // RULE11

      // Plain field copies for the analog side, plus the pulse width lookup.
      s_next.chan_div = s_reg.r3[CHAN_DIV_LSB +: 5];
      s_next.ref_range = s_reg.r5[REF_RANGE_LSB +: 3];
      s_next.pump_code = s_reg.r4[PUMP_CODE_LSB +: 3];
      s_next.pump_ps = pulse_ps(s_reg.r4[PUMP_CODE_LSB +: 3]); // RULE17
   end

   // ==========================================================================
   // State register; the clock enable freezes everything.
   always_ff @(posedge clock) begin
      if (srst) begin
         s_reg <= '0;
         s_reg.r0 <= R0_RESET;
         s_reg.r1 <= R1_RESET;
         s_reg.r3 <= R3_RESET;
         s_reg.r4 <= R4_RESET;
         s_reg.r5 <= R5_RESET;
         s_reg.r6 <= R6_RESET;
         s_reg.pstat <= PWR_UP;
         s_reg.pump_ps <= PULSE_PS_0;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   // ==========================================================================
   // Outputs straight from the state flip-flops.
   assign digital_lock_flag = s_reg.lock_flag;
   assign power = s_reg.power;
   assign power_status = s_reg.pstat;
   assign route = s_reg.route;
   assign channel_divide_value = s_reg.chan_div;
   assign ref_freq_range = s_reg.ref_range;
   assign pump_min_pulse_code = s_reg.pump_code;
   assign pump_min_pulse_ps = s_reg.pump_ps;
   assign cal = s_reg.cal;
   assign soft_reset_active = s_reg.soft_active;
   assign program_lockout = s_reg.r6[LOCKOUT_BIT];

endmodule : synth_control_field_decode

// ---- hdl/synth_ctl_pkg.sv ----
// Package with register map, field layout, timing and carrier types of the control decode.
package synth_ctl_pkg;

   // ==========================================================================
   // Register addresses, carried in the low nibble of each serial word.
   localparam logic [3:0] ADDR_R0 = 4'h0;
   localparam logic [3:0] ADDR_R1 = 4'h1;
   localparam logic [3:0] ADDR_R3 = 4'h3;
   localparam logic [3:0] ADDR_PUMP_PULSE_TIMING_CONFIG = 4'h4;
   localparam logic [3:0] ADDR_OUTPUT_POWER_MODE_CONFIG = 4'h5;
   localparam logic [3:0] ADDR_R6 = 4'h6;

   // ==========================================================================
   // Field positions (low bit of each field).
   localparam int SKIP_FREQ_CAL_BIT = 4;
   localparam int CORE_START_LSB = 4;
   localparam int CHAN_DIV_LSB = 4;
   localparam int PUMP_CODE_LSB = 4;
   localparam int LOCKOUT_BIT = 4;
   localparam int SOFT_RESET_BIT = 4;
   localparam int PWDN_LSB = 5;
   localparam int MODE_LSB = 8;
   localparam int DET_DELAY_BIT = 10;
   localparam int OUT_A_SRC_LSB = 11;
   localparam int OUT_B_SRC_LSB = 13;
   localparam int CORE_PICK_LSB = 15;
   localparam int BUF_IGNORE_BIT = 17;
   localparam int REF_RANGE_LSB = 18;
   localparam int MUTE_BIT = 21;

   // ==========================================================================
   // Values after reset of every held register word.
   localparam logic [31:0] R0_RESET = 32'h0000_0000;
   localparam logic [31:0] R1_RESET = 32'h0000_0001;
   localparam logic [31:0] R3_RESET = 32'h0000_0003;
   localparam logic [31:0] R4_RESET = 32'h0000_0004;
   localparam logic [31:0] R5_RESET = 32'h0000_0005;
   localparam logic [31:0] R6_RESET = 32'h0000_0006;

   // ==========================================================================
   // Timing of the self-releasing register reset.
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int SOFT_RESET_TIME_NS = 100;
   localparam int SOFT_RESET_CYCLES = (SOFT_RESET_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   // ==========================================================================
   // Charge pump minimum on time in ps for each code 0..7.
   localparam logic [11:0] PULSE_PS_0 = 12'h172;
   localparam logic [11:0] PULSE_PS_1 = 12'h2F8;
   localparam logic [11:0] PULSE_PS_2 = 12'h46A;
   localparam logic [11:0] PULSE_PS_3 = 12'h5B4;
   localparam logic [11:0] PULSE_PS_4 = 12'h6EA;
   localparam logic [11:0] PULSE_PS_5 = 12'h816;
   localparam logic [11:0] PULSE_PS_6 = 12'h92E;
   localparam logic [11:0] PULSE_PS_7 = 12'hA28;

   // ==========================================================================
   // Carrier types.
   typedef enum logic [2:0] {
      PWR_UP = 3'b001,
      PWR_FULL_DOWN = 3'b010,
      PWR_PARTIAL_DOWN = 3'b100
   } power_status_t;

   typedef struct packed {
      logic clk;
      logic data;
      logic latch;
   } ser_pins_t;

   typedef struct packed {
      logic pll_on;
      logic vco_on;
      logic ext_in_on;
      logic regulators_on;
   } power_ctl_t;

   typedef struct packed {
      logic out_a_en;
      logic out_b_en;
      logic [1:0] out_a_sel;
      logic [1:0] out_b_sel;
      logic feedback_from_divider;
   } rf_route_t;

   typedef struct packed {
      logic start;
      logic [1:0] core;
      logic forced;
   } cal_req_t;

endpackage : synth_ctl_pkg

// ---- verif/synth_control_field_decode_monitor.sv ----
// Checker of the control decode outputs, bound to the top module.
`timescale 1ns/1ps
module synth_control_field_decode_monitor
   import synth_ctl_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire ser_pins_t ser_pins,
   input wire logic phase_lock_raw,
   input wire logic digital_lock_flag,
   input wire power_ctl_t power,
   input wire power_status_t power_status,
   input wire rf_route_t route,
   input wire logic [2:0] pump_min_pulse_code,
   input wire logic [11:0] pump_min_pulse_ps,
   input wire cal_req_t cal,
   input wire logic soft_reset_active,
   input wire logic program_lockout
);
   // ==========================================================================
   // Pulse width in ps for each code.
   localparam logic [11:0] PS [8] = '{12'h172, 12'h2F8, 12'h46A, 12'h5B4,
      12'h6EA, 12'h816, 12'h92E, 12'hA28};

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   // Ten cycles of the self-releasing reset.
   sequence soft_run;
      soft_reset_active [*8] ##1 soft_reset_active ##1 soft_reset_active;
   endsequence

   // Lock input held steady long enough to pass the synchroniser.
   sequence lock_held(v);
      (phase_lock_raw == v) [*6];
   endsequence

   AST_PULSE_MAP: assert property ($stable(pump_min_pulse_code) |->
      pump_min_pulse_ps == PS[pump_min_pulse_code]) else $error("pulse width mismatch");
   AST_PARTIAL: assert property (power_status == PWR_PARTIAL_DOWN && $stable(power_status) |->
      !power.pll_on && !power.vco_on && power.regulators_on) else $error("partial power bad");
   AST_FULL: assert property (power_status == PWR_FULL_DOWN && $stable(power_status) |->
      !power.pll_on && !power.regulators_on) else $error("full power down bad");
   AST_OUT_UP: assert property ((route.out_a_en || route.out_b_en) && $stable(power_status)
      |-> power_status == PWR_UP) else $error("output on while powered down");
   AST_SOFT_LEN: assert property ($rose(soft_reset_active) |-> soft_run ##1
      !soft_reset_active) else $error("register reset length wrong");
   AST_SOFT_CLR: assert property (soft_reset_active [*3] |->
      pump_min_pulse_code == 3'h0 && !program_lockout) else $error("reset left fields set");
   AST_CAL_PULSE: assert property (cal.start |=> !cal.start) else $error("cal start too long");
   AST_LOCK_HI: assert property (lock_held(1'b1) |-> digital_lock_flag)
      else $error("lock flag low while locked");
   AST_LOCK_LO: assert property (lock_held(1'b0) |-> !digital_lock_flag)
      else $error("lock flag high while unlocked");
   AST_LATCHED: assert property ($changed(pump_min_pulse_code) |-> $past(ser_pins.latch, 4)
      || $past(ser_pins.latch, 5) || $past(ser_pins.latch, 6)) else $error("field moved unlatched");
endmodule : synth_control_field_decode_monitor

bind synth_control_field_decode synth_control_field_decode_monitor mon (.clock, .srst, .ser_pins,
   .phase_lock_raw, .digital_lock_flag, .power, .power_status, .route, .pump_min_pulse_code,
   .pump_min_pulse_ps, .cal, .soft_reset_active, .program_lockout);

// ---- verif/synth_host_model.sv ----
// Host model that drives the three-wire serial pins of the control decode.
`timescale 1ns/1ps
module synth_host_model
   import synth_ctl_pkg::*;
(
   output ser_pins_t ser_pins
);
   // ==========================================================================
   // Serial clock stands low between words; one bit takes 125 ns.
   initial begin
      ser_pins = '{clk: 1'b0, data: 1'b0, latch: 1'b0};
   end

   // Shift one word MSB first, then raise latch.
   // Data turns to its inverse once its hold time has run out.
   // A late sampler therefore picks up a wrong bit instead of a lucky one.
   task automatic send(input logic [31:0] word);
      for (int i = 31; i >= 0; i--) begin
         ser_pins.data = word[i];
         #62.5 ser_pins.clk = 1'b1;
         #50 ser_pins.data = ~word[i];
         #12.5 ser_pins.clk = 1'b0;
      end
      #62.5 ser_pins.latch = 1'b1;
      #100 ser_pins.latch = 1'b0;
      #100;
   endtask : send
endmodule : synth_host_model

// ---- verif/tb_synth_control_field_decode.sv ----
// Self-checking bench of the control decode, driven through the serial pins.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_count++; \
   $display("unexpected %s: expected %0h, seen %0h", nm, ex, got); end end
module tb_synth_control_field_decode
   import synth_ctl_pkg::*;
;
   // ==========================================================================
   // Stimulus and observed signals.
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic chip_enable_pin = 1'b1;
   logic buffer_enable_pin = 1'b1;
   logic phase_lock_raw = 1'b1;
   logic [3:0] core_valid = 4'hF;
   logic clk_en = 1'b1; // Clock enable of the decode; dropped once to prove the freeze.
   ser_pins_t ser_pins;
   logic digital_lock_flag, soft_reset_active, program_lockout;
   power_ctl_t power;
   power_status_t power_status;
   rf_route_t route;
   logic [4:0] chan_div;
   logic [2:0] ref_freq_range, pump_min_pulse_code;
   logic [11:0] pump_min_pulse_ps;
   cal_req_t cal;
   int err_count = 0;
   int cmp_count = 0;
   int pulse_cnt = 0;
   localparam logic [31:0] R5B = 32'h0000_0005; // Register five with all fields zero.
   localparam logic [11:0] PS [8] = '{12'h172, 12'h2F8, 12'h46A, 12'h5B4,
      12'h6EA, 12'h816, 12'h92E, 12'hA28};
   // Calibration table: core-pick method, valid mask, expected core and forced flag.
   // The last row uses reserved method 3, which must behave as method 0.
   logic [1:0] cp_t [5] = '{2'd1, 2'd2, 2'd1, 2'd0, 2'd3};
   logic [3:0] vl_t [5] = '{4'hB, 4'hB, 4'hF, 4'hF, 4'hF};
   logic [1:0] co_t [5] = '{2'd0, 2'd2, 2'd2, 2'd2, 2'd2};
   logic fo_t [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

   always #5 clock = ~clock;

   synth_host_model host (.ser_pins(ser_pins));
   synth_control_field_decode uut (.clock(clock), .srst(srst), .clk_en(clk_en),
      .ser_pins(ser_pins), .chip_enable_pin(chip_enable_pin),
      .buffer_enable_pin(buffer_enable_pin), .phase_lock_raw(phase_lock_raw),
      .core_valid(core_valid), .digital_lock_flag(digital_lock_flag), .power(power),
      .power_status(power_status), .route(route), .channel_divide_value(chan_div),
      .ref_freq_range(ref_freq_range), .pump_min_pulse_code(pump_min_pulse_code),
      .pump_min_pulse_ps(pump_min_pulse_ps), .cal(cal),
      .soft_reset_active(soft_reset_active), .program_lockout(program_lockout));

   // Count calibration start pulses; each stands for one cycle only.
   always @(posedge clock) begin
      if (cal.start === 1'b1) pulse_cnt <= pulse_cnt + 1;
   end

   // Send one word at a falling edge and let the decode settle.
   task automatic wr(input logic [31:0] w);
      @(negedge clock);
      host.send(w);
      repeat (4) @(negedge clock);
   endtask : wr

   // Expected device status for a power-down code and chip-enable level.
   function automatic power_status_t exp_pwr(input int p, input logic ce);
      case (p)
         1: exp_pwr = PWR_FULL_DOWN;
         3: exp_pwr = PWR_PARTIAL_DOWN;
         4: exp_pwr = ce ? PWR_UP : PWR_FULL_DOWN;
         6: exp_pwr = ce ? PWR_UP : PWR_PARTIAL_DOWN;
         7: exp_pwr = ce ? PWR_PARTIAL_DOWN : PWR_FULL_DOWN;
         default: exp_pwr = PWR_UP;
      endcase
   endfunction : exp_pwr

   // Print the counts and the verdict, then stop.
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   // Watchdog sized well beyond the roughly 210 us of serial traffic.
   initial begin
      #400us;
      err_count++;
      $display("unexpected run time: expected done, seen timeout");
      end_of_test();
   end

   // ==========================================================================
   // Main sequence of writes and checks.
   initial begin
      int n;
      repeat (16) @(negedge clock);
      srst = 1'b0;
      repeat (4) @(negedge clock);
      `CHK("status", PWR_UP, power_status)
      `CHK("route", 7'b1100000, route)
      `CHK("lock", 1'b1, digital_lock_flag)
      for (int i = 7; i >= 0; i--) begin
         wr({25'h0, i[2:0], 4'h4});
         `CHK("pulse code", i[2:0], pump_min_pulse_code)
         `CHK("pulse ps", PS[i], pump_min_pulse_ps)
      end
      for (int p = 0; p < 8; p++) begin
         wr(R5B | (32'(p) << PWDN_LSB));
         for (int c = 0; c < 2; c++) begin
            chip_enable_pin = c[0];
            repeat (8) @(negedge clock);
            `CHK("power status", exp_pwr(p, c[0]), power_status)
         end
      end
      for (int i = 0; i < 4; i++) begin
         wr(R5B | (32'(i) << OUT_A_SRC_LSB) | (32'(3 - i) << OUT_B_SRC_LSB)
            | (32'(i % 2) << DET_DELAY_BIT));
         `CHK("route", {i != 3, i != 0, i[1:0], 2'd3 - i[1:0], i[0]}, route)
      end
      for (int m = 0; m < 2; m++) begin
         wr(R5B | (32'(m) << MODE_LSB));
         `CHK("power", {1'b1, m == 0, 1'b0, 1'b1}, power)
      end
      buffer_enable_pin = 1'b0;
      repeat (8) @(negedge clock);
      `CHK("out a enable", 1'b0, route.out_a_en)
      wr(R5B | (32'h1 << BUF_IGNORE_BIT));
      `CHK("out a enable", 1'b1, route.out_a_en)
      buffer_enable_pin = 1'b1;
      wr(R5B | (32'h1 << MUTE_BIT));
      for (int k = 0; k < 2; k++) begin
         phase_lock_raw = k[0];
         repeat (8) @(negedge clock);
         `CHK("outputs", {k[0], k[0]}, {route.out_a_en, route.out_b_en})
      end
      // With the clock enable low even the pin synchronisers hold, so the outputs stay.
      clk_en = 1'b0;
      buffer_enable_pin = 1'b0;
      repeat (8) @(negedge clock);
      `CHK("frozen out a enable", 1'b1, route.out_a_en)
      clk_en = 1'b1;
      repeat (8) @(negedge clock);
      `CHK("out a enable", 1'b0, route.out_a_en)
      buffer_enable_pin = 1'b1;
      for (int r = 0; r < 5; r++) begin
         wr(R5B | (32'(r) << REF_RANGE_LSB));
         `CHK("ref range", r[2:0], ref_freq_range)
      end
      wr(32'h0000_0093); // Channel divide code 9.
      `CHK("chan div", 5'h09, chan_div)
      wr(32'h0000_0021); // Start choice is core 2.
      for (int i = 0; i < 5; i++) begin
         core_valid = vl_t[i];
         wr(R5B | (32'(cp_t[i]) << CORE_PICK_LSB));
         n = pulse_cnt;
         wr(32'h0000_0000);
         `CHK("cal pulses", n + 1, pulse_cnt)
         `CHK("cal core", co_t[i], cal.core)
         `CHK("cal forced", fo_t[i], cal.forced)
      end
      wr(32'h0000_0010);
      `CHK("cal pulses", n + 1, pulse_cnt)
      wr(32'h0000_0054);
      wr(32'h0000_0016);
      `CHK("lockout", 1'b1, program_lockout)
      wr(32'h0000_0024);
      `CHK("pulse code", 3'h5, pump_min_pulse_code)
      wr(32'h0000_0006);
      wr(32'h0000_0024);
      `CHK("pulse code", 3'h2, pump_min_pulse_code)
      wr(R5B | 32'h10);
      repeat (20) @(negedge clock);
      `CHK("pulse code", 3'h0, pump_min_pulse_code)
      `CHK("reset active", 1'b0, soft_reset_active)
      wr(32'h0000_0000);
      `CHK("cal core", 2'd0, cal.core)
      end_of_test();
   end
endmodule : tb_synth_control_field_decode
